//--- hdl/mid_pkg.sv
// constants and types shared by the instruction decode and timing block
// assumes one oscillator-rate clock and a 13-bit program word
package mid_pkg;

	localparam int WORD_W = 13;
	localparam int DATA_W = 8;
	localparam int PC_W   = 10;

	// code option word: instruction cycle length select
	localparam int CFG_CYCLE_CLK_BIT = 10;
	localparam logic [1:0] PHASE_LAST_2CLK = 2'h1;
	localparam logic [1:0] PHASE_LAST_4CLK = 2'h3;

	// register designators decoded inside the core
	localparam logic [5:0] REG_PC     = 6'h02;
	localparam logic [5:0] REG_STATUS = 6'h03;
	localparam logic [5:0] REG_BANK   = 6'h04;
	localparam int BANK_LO = 6;
	localparam int BANK_HI = 7;

	// status register fields and reset value
	localparam int ST_CARRY = 0;
	localparam int ST_DIGIT = 1;
	localparam int ST_ZERO  = 2;
	localparam int ST_PWRDN = 3;
	localparam int ST_TIMEO = 4;
	localparam logic [7:0] STATUS_RST = 8'h18;

	localparam logic [PC_W-1:0] SW_INT_VECTOR = 10'h002;

	// fixed encodings
	localparam logic [12:0] ENC_NOP     = 13'h0000;
	localparam logic [12:0] ENC_DAA     = 13'h0001;
	localparam logic [12:0] ENC_CONTW   = 13'h0002;
	localparam logic [12:0] ENC_SLEEP   = 13'h0003;
	localparam logic [12:0] ENC_WDCLR   = 13'h0004;
	localparam logic [12:0] ENC_ENI     = 13'h0010;
	localparam logic [12:0] ENC_DISI    = 13'h0011;
	localparam logic [12:0] ENC_RET     = 13'h0012;
	localparam logic [12:0] ENC_RET_INT = 13'h0013;
	localparam logic [12:0] ENC_CONTR   = 13'h0014;
	localparam logic [12:0] ENC_TABLE   = 13'h0020;
	localparam logic [12:0] ENC_CLRA    = 13'h0080;
	localparam logic [12:0] ENC_SW_INT  = 13'h1E02;
	localparam logic [3:0]  IOC_FIRST   = 4'h5;

	typedef enum logic [4:0] {
		OP_NOP, OP_DAA, OP_CONTW, OP_CONTR, OP_SLEEP, OP_WDCLR, OP_IOW, OP_IOR,
		OP_ENI, OP_DISI, OP_RET, OP_RET_INT, OP_RETL, OP_TABLE_ADD, OP_REG,
		OP_LIT, OP_SKIP_CLR, OP_SKIP_SET, OP_CALL, OP_JMP, OP_SW_INT
	} mid_op_t;

	typedef enum logic [4:0] {
		ALU_MOVA, ALU_CLR, ALU_SUB, ALU_DEC, ALU_OR, ALU_AND, ALU_XOR, ALU_ADD,
		ALU_MOV, ALU_COM, ALU_INC, ALU_DEC_SKIP, ALU_RRC, ALU_RLC, ALU_SWAP,
		ALU_INC_SKIP, ALU_BC, ALU_BS
	} mid_alu_t;

endpackage

//--- hdl/mid_decode.sv
// combinational instruction word decoder
// assumes the word is held stable for the whole instruction cycle
module mid_decode
	import mid_pkg::*;
(
	// instruction word
	input  wire logic [WORD_W-1:0] word,
	// decoded fields
	output mid_op_t                op,
	output mid_alu_t               alu,
	output logic                   to_reg,
	output logic                   lit_op,
	output logic [5:0]             reg_sel,
	output logic [2:0]             bit_sel,
	output logic [PC_W-1:0]        lit
);

	assign lit     = word[PC_W-1:0];
	assign bit_sel = word[8:6];
	assign reg_sel = word[5:0];

	always_comb begin
		op     = OP_NOP;
		alu    = ALU_MOV;
		to_reg = 1'b0;
		lit_op = 1'b0;
		if (word[12]) begin
			lit_op = 1'b1;
			op     = OP_LIT;
			if (!word[11]) begin
				op = word[10] ? OP_JMP : OP_CALL;
			end else begin
				unique case (word[10:8])
					3'h0: alu = ALU_MOV;
					3'h1: alu = ALU_OR;
					3'h2: alu = ALU_AND;
					3'h3: alu = ALU_XOR;
					3'h4: op = OP_RETL;
					3'h5: alu = ALU_SUB;
					3'h6: op = (word == ENC_SW_INT) ? OP_SW_INT : OP_NOP;
					3'h7: alu = ALU_ADD;
				endcase
			end
		end else if (word[11]) begin
			unique case (word[10:9])
				2'h0: begin
					op     = OP_REG;
					alu    = ALU_BC;
					to_reg = 1'b1;
				end
				2'h1: begin
					op     = OP_REG;
					alu    = ALU_BS;
					to_reg = 1'b1;
				end
				2'h2: op = OP_SKIP_CLR;
				2'h3: op = OP_SKIP_SET;
			endcase
		end else if (word[10:8] != 3'h0) begin
			op     = OP_REG;
			to_reg = word[6];
			unique case (word[10:7])
				4'h2: alu = ALU_SUB;
				4'h3: alu = ALU_DEC;
				4'h4: alu = ALU_OR;
				4'h5: alu = ALU_AND;
				4'h6: alu = ALU_XOR;
				4'h7: alu = ALU_ADD;
				4'h8: alu = ALU_MOV;
				4'h9: alu = ALU_COM;
				4'hA: alu = ALU_INC;
				4'hB: alu = ALU_DEC_SKIP;
				4'hC: alu = ALU_RRC;
				4'hD: alu = ALU_RLC;
				4'hE: alu = ALU_SWAP;
				default: alu = ALU_INC_SKIP;
			endcase
		end else begin
			unique case (word[7:6])
				2'h0: begin
					unique case (word)
						ENC_NOP:     op = OP_NOP;
						ENC_DAA:     op = OP_DAA;
						ENC_CONTW:   op = OP_CONTW;
						ENC_SLEEP:   op = OP_SLEEP;
						ENC_WDCLR:   op = OP_WDCLR;
						ENC_ENI:     op = OP_ENI;
						ENC_DISI:    op = OP_DISI;
						ENC_RET:     op = OP_RET;
						ENC_RET_INT: op = OP_RET_INT;
						ENC_CONTR:   op = OP_CONTR;
						ENC_TABLE:   op = OP_TABLE_ADD;
						default: begin
							if (word[5:4] == 2'h0 && word[3:0] >= IOC_FIRST)
								op = OP_IOW;
							else if (word[5:4] == 2'h1 && word[3:0] >= IOC_FIRST)
								op = OP_IOR;
						end
					endcase
				end
				2'h1: begin
					op     = OP_REG;
					alu    = ALU_MOVA;
					to_reg = 1'b1;
				end
				2'h2: begin
					op  = (word == ENC_CLRA) ? OP_REG : OP_NOP;
					alu = ALU_CLR;
				end
				2'h3: begin
					op     = OP_REG;
					alu    = ALU_CLR;
					to_reg = 1'b1;
				end
			endcase
		end
	end

endmodule

//--- hdl/mid_core.sv
// instruction fetch, decode, execute and cycle timing for the 8-bit core
// assumes program memory and the register file outside read asynchronously

module mid_core
	import mid_pkg::*;
#(
	parameter int              STACK_DEPTH = 8,
	parameter logic [PC_W-1:0] RESET_PC    = 10'h000
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// code option word
	input  wire logic [WORD_W-1:0] cfg_word,
	// program memory
	output logic      [PC_W-1:0]   prog_addr,
	input  wire logic [WORD_W-1:0] prog_data,
	// register file and I/O registers
	output logic      [7:0]        reg_addr,
	output logic      [7:0]        reg_wdata,
	output logic                   reg_we,
	input  wire logic [7:0]        reg_rdata,
	// I/O control registers
	output logic      [3:0]        ioc_sel,
	output logic      [7:0]        ioc_wdata,
	output logic                   ioc_we,
	input  wire logic [7:0]        ioc_rdata,
	// core state
	output logic      [7:0]        acc,
	output logic      [7:0]        status,
	output logic      [7:0]        bank_select_register,
	output logic      [7:0]        cont,
	output logic                   gie,
	output logic                   osc_stop,
	output logic                   watchdog_clear,
	output logic                   cycle_end
);

	localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	logic [2:0]        cks_sync_r;
	logic              cks_r;
	logic [1:0]        phase_r;
	logic              bubble_r;
	logic [WORD_W-1:0] ir_r;
	logic [PC_W-1:0]   pc_r;
	logic [PC_W-1:0]   stack_r [STACK_DEPTH];
	logic [SP_W-1:0]   sp_r;
	logic [7:0]        acc_r;
	logic [7:0]        status_r;
	logic [7:0]        bank_r;
	logic [7:0]        cont_r;
	logic              gie_r;
	logic              stop_r;
	logic [7:0]        reg_addr_r;
	logic [7:0]        reg_wdata_r;
	logic              reg_we_r;
	logic              ioc_we_r;
	logic [7:0]        ioc_wdata_r;
	logic              wd_clr_r;
	logic              cycle_end_r;

	mid_op_t           d_op;
	mid_alu_t          d_alu;
	logic              d_to_reg;
	logic              d_lit_op;
	logic [5:0]        d_reg;
	logic [2:0]        d_bit;
	logic [PC_W-1:0]   d_lit;

	mid_decode u_decode (
		.word    (ir_r),
		.op      (d_op),
		.alu     (d_alu),
		.to_reg  (d_to_reg),
		.lit_op  (d_lit_op),
		.reg_sel (d_reg),
		.bit_sel (d_bit),
		.lit     (d_lit)
	);

	wire [1:0] phase_last = cks_r ? PHASE_LAST_4CLK : PHASE_LAST_2CLK;
	wire       fetch_edge = (phase_r == 2'h0) && !stop_r;
	wire       exec_edge  = (phase_r >= phase_last) && !stop_r;
	wire       exec_ok    = exec_edge && !bubble_r;

	// only PC, status and bank live here; I/O registers come from outside
	wire       sel_pc     = (d_reg == REG_PC);
	wire       sel_status = (d_reg == REG_STATUS);
	wire       sel_bank   = (d_reg == REG_BANK);
	wire [7:0] reg_val    = sel_pc ? pc_r[7:0] : sel_status ? status_r :
	                        sel_bank ? bank_r : reg_rdata;
	wire [7:0] opnd       = d_lit_op ? d_lit[7:0] : reg_val;
	wire [7:0] bit_mask   = 8'h01 << d_bit;
	wire [PC_W-1:0] pc_inc  = pc_r + 10'h001;
	wire [PC_W-1:0] pc_skip = pc_r + 10'h002;
	wire [SP_W-1:0] sp_dec  = sp_r - 1'b1;

	// table add on the low PC byte
	wire [8:0] tbl_sum = {1'b0, pc_r[7:0]} + {1'b0, acc_r};
	wire [4:0] tbl_dig = {1'b0, pc_r[3:0]} + {1'b0, acc_r[3:0]};

	wire [8:0] daa_a  = {1'b0, acc_r} + ((acc_r[3:0] > 4'h9) ? 9'h006 : 9'h000);
	wire       daa_hi = (daa_a[7:4] > 4'h9) || daa_a[8] || status_r[ST_CARRY];
	wire [8:0] daa_b  = daa_a + (daa_hi ? 9'h060 : 9'h000);

	logic [7:0] alu_res;
	logic       alu_c;
	logic       alu_dig;
	logic [8:0] sum9;
	logic [4:0] sum5;

	always_comb begin
		sum9    = '0;
		sum5    = '0;
		alu_res = opnd;
		alu_c   = status_r[ST_CARRY];
		alu_dig = status_r[ST_DIGIT];
		unique case (d_alu)
			ALU_MOVA: alu_res = acc_r;
			ALU_CLR:  alu_res = '0;
			ALU_SUB: begin
				sum9    = {1'b0, opnd} + {1'b0, ~acc_r} + 9'h001;
				sum5    = {1'b0, opnd[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;
				alu_res = sum9[7:0];
				alu_c   = sum9[8];
				alu_dig = sum5[4];
			end
			ALU_ADD: begin
				sum9    = {1'b0, opnd} + {1'b0, acc_r};
				sum5    = {1'b0, opnd[3:0]} + {1'b0, acc_r[3:0]};
				alu_res = sum9[7:0];
				alu_c   = sum9[8];
				alu_dig = sum5[4];
			end
			ALU_DEC, ALU_DEC_SKIP: alu_res = opnd - 8'h01;
			ALU_INC, ALU_INC_SKIP: alu_res = opnd + 8'h01;
			ALU_OR:   alu_res = opnd | acc_r;
			ALU_AND:  alu_res = opnd & acc_r;
			ALU_XOR:  alu_res = opnd ^ acc_r;
			ALU_MOV:  alu_res = opnd;
			ALU_COM:  alu_res = ~opnd;
			ALU_RRC: begin
				alu_res = {status_r[ST_CARRY], opnd[7:1]};
				alu_c   = opnd[0];
			end
			ALU_RLC: begin
				alu_res = {opnd[6:0], status_r[ST_CARRY]};
				alu_c   = opnd[7];
			end
			ALU_SWAP: alu_res = {opnd[3:0], opnd[7:4]};
			ALU_BC:   alu_res = opnd & ~bit_mask;
			ALU_BS:   alu_res = opnd | bit_mask;
		endcase
	end

	wire alu_op  = (d_op == OP_REG) || (d_op == OP_LIT);
	wire upd_cd  = alu_op && (d_alu == ALU_SUB || d_alu == ALU_ADD);
	wire upd_c   = upd_cd || (alu_op && (d_alu == ALU_RRC || d_alu == ALU_RLC));
	wire upd_z   = upd_cd || (alu_op && !(d_lit_op && d_alu == ALU_MOV) &&
	               (d_alu inside {ALU_CLR, ALU_DEC, ALU_OR, ALU_AND, ALU_XOR,
	                              ALU_MOV, ALU_COM, ALU_INC}));

	logic [PC_W-1:0] pc_nxt;
	logic [7:0]      acc_nxt;
	logic [7:0]      status_nxt;
	logic [7:0]      bank_nxt;
	logic [7:0]      cont_nxt;
	logic            gie_nxt;
	logic            stop_nxt;
	logic            push;
	logic            pop;
	logic            two_cyc;
	logic            skip;
	logic            wr_reg;
	logic            reg_we_nxt;
	logic            wd_clr_nxt;

	always_comb begin
		pc_nxt     = pc_inc;
		acc_nxt    = acc_r;
		status_nxt = status_r;
		bank_nxt   = bank_r;
		cont_nxt   = cont_r;
		gie_nxt    = gie_r;
		stop_nxt   = stop_r;
		push       = 1'b0;
		pop        = 1'b0;
		two_cyc    = 1'b0;
		skip       = 1'b0;
		wr_reg     = 1'b0;
		reg_we_nxt = 1'b0;
		wd_clr_nxt = 1'b0;
		unique case (d_op)
			OP_NOP: ;
			OP_DAA: begin
				acc_nxt              = daa_b[7:0];
				status_nxt[ST_CARRY] = daa_hi;
			end
			OP_CONTW: cont_nxt = acc_r;
			OP_CONTR: acc_nxt = cont_r;
			OP_SLEEP: begin
				wd_clr_nxt           = 1'b1;
				stop_nxt             = 1'b1;
				status_nxt[ST_TIMEO] = 1'b1;
				status_nxt[ST_PWRDN] = 1'b0;
			end
			OP_WDCLR: begin
				wd_clr_nxt           = 1'b1;
				status_nxt[ST_TIMEO] = 1'b1;
				status_nxt[ST_PWRDN] = 1'b1;
			end
			OP_IOW: ;
			OP_IOR: acc_nxt = ioc_rdata;
			OP_ENI: gie_nxt = 1'b1;
			OP_DISI: gie_nxt = 1'b0;
			OP_RET: pop = 1'b1;
			OP_RET_INT: begin
				pop     = 1'b1;
				gie_nxt = 1'b1;
			end
			OP_RETL: begin
				pop     = 1'b1;
				acc_nxt = d_lit[7:0];
			end
			OP_TABLE_ADD: begin
				pc_nxt               = {pc_r[9:8], tbl_sum[7:0]};
				two_cyc              = 1'b1;
				status_nxt[ST_ZERO]  = (tbl_sum[7:0] == 8'h00);
				status_nxt[ST_CARRY] = tbl_sum[8];
				status_nxt[ST_DIGIT] = tbl_dig[4];
			end
			OP_REG, OP_LIT: begin
				wr_reg = d_to_reg;
				if (!d_to_reg)
					acc_nxt = alu_res;
				skip = (d_alu == ALU_DEC_SKIP || d_alu == ALU_INC_SKIP) &&
				       (alu_res == 8'h00);
			end
			OP_SKIP_CLR: skip = !opnd[d_bit];
			OP_SKIP_SET: skip = opnd[d_bit];
			OP_CALL, OP_JMP: begin
				push    = (d_op == OP_CALL);
				pc_nxt  = d_lit;
				two_cyc = 1'b1;
			end
			OP_SW_INT: begin
				push    = 1'b1;
				pc_nxt  = SW_INT_VECTOR;
				two_cyc = 1'b1;
			end
		endcase
		if (wr_reg) begin
			if (sel_pc) begin
				pc_nxt  = {pc_r[9:8], alu_res};
				two_cyc = 1'b1;
			end else if (sel_status)
				status_nxt = alu_res;
			else if (sel_bank)
				bank_nxt = alu_res;
			else
				reg_we_nxt = 1'b1;
		end
		if (upd_z)
			status_nxt[ST_ZERO] = (alu_res == 8'h00);
		if (upd_c)
			status_nxt[ST_CARRY] = alu_c;
		if (upd_cd)
			status_nxt[ST_DIGIT] = alu_dig;
		if (skip) begin
			pc_nxt  = pc_skip;
			two_cyc = 1'b1;
		end
		if (pop) begin
			pc_nxt  = stack_r[sp_dec];
			two_cyc = 1'b1;
		end
	end

	// option bit crosses in from a pin: change taken once stages two and three agree
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cks_sync_r <= '0;
			cks_r      <= 1'b0;
		end else begin
			cks_sync_r <= {cks_sync_r[1:0], cfg_word[CFG_CYCLE_CLK_BIT]};
			if (cks_sync_r[1] == cks_sync_r[2])
				cks_r <= cks_sync_r[2];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			phase_r <= 2'h0;
		else if (!stop_r)
			phase_r <= exec_edge ? 2'h0 : phase_r + 2'h1;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ir_r       <= ENC_NOP;
			reg_addr_r <= 8'h00;
		end else if (fetch_edge) begin
			ir_r       <= prog_data;
			reg_addr_r <= {bank_r[BANK_HI:BANK_LO], prog_data[5:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (exec_ok && push)
			stack_r[sp_r] <= pc_inc;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pc_r     <= RESET_PC;
			sp_r     <= '0;
			bubble_r <= 1'b0;
			acc_r    <= 8'h00;
			status_r <= STATUS_RST;
			bank_r   <= 8'h00;
			cont_r   <= 8'h00;
			gie_r    <= 1'b0;
			stop_r   <= 1'b0;
		end else if (exec_ok) begin
			pc_r     <= pc_nxt;
			sp_r     <= push ? sp_r + 1'b1 : pop ? sp_dec : sp_r;
			bubble_r <= two_cyc;
			acc_r    <= acc_nxt;
			status_r <= status_nxt;
			bank_r   <= bank_nxt;
			cont_r   <= cont_nxt;
			gie_r    <= gie_nxt;
			stop_r   <= stop_nxt;
		end else if (exec_edge) begin
			bubble_r <= 1'b0;
		end
	end

	// strobes last one clock, so the write lands at the edge after execute
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_we_r    <= 1'b0;
			reg_wdata_r <= 8'h00;
			ioc_we_r    <= 1'b0;
			ioc_wdata_r <= 8'h00;
			wd_clr_r    <= 1'b0;
			cycle_end_r <= 1'b0;
		end else begin
			reg_we_r    <= exec_ok && reg_we_nxt;
			ioc_we_r    <= exec_ok && (d_op == OP_IOW);
			wd_clr_r    <= exec_ok && wd_clr_nxt;
			cycle_end_r <= exec_edge;
			if (exec_ok) begin
				reg_wdata_r <= alu_res;
				ioc_wdata_r <= acc_r;
			end
		end
	end

	assign prog_addr            = pc_r;
	assign reg_addr             = reg_addr_r;
	assign reg_wdata            = reg_wdata_r;
	assign reg_we               = reg_we_r;
	assign ioc_sel              = ir_r[3:0];
	assign ioc_wdata            = ioc_wdata_r;
	assign ioc_we               = ioc_we_r;
	assign acc                  = acc_r;
	assign status               = status_r;
	assign bank_select_register = bank_r;
	assign cont                 = cont_r;
	assign gie                  = gie_r;
	assign osc_stop             = stop_r;
	assign watchdog_clear       = wd_clr_r;
	assign cycle_end            = cycle_end_r;

endmodule

//--- verification/mid_core_properties.sv
// port-level timing and content checks for the decode and timing core
// assumes cfg_word changes only while nrst is low
module mid_core_properties
	import mid_pkg::*;
(
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              nrst,
	// configuration and program side
	input wire logic [WORD_W-1:0] cfg_word,
	input wire logic [PC_W-1:0]   prog_addr,
	// register ports
	input wire logic [7:0]        reg_addr,
	input wire logic              reg_we,
	input wire logic [3:0]        ioc_sel,
	input wire logic [7:0]        ioc_wdata,
	input wire logic              ioc_we,
	// core state
	input wire logic [7:0]        acc,
	input wire logic [7:0]        status,
	input wire logic [7:0]        bank_select_register,
	input wire logic              gie,
	input wire logic              osc_stop,
	input wire logic              watchdog_clear,
	input wire logic              cycle_end
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	cycle_two_a: assert property (
		(!cfg_word[CFG_CYCLE_CLK_BIT])[*8] ##0 (cycle_end && !osc_stop) |=> !cycle_end ##1 cycle_end)
		else $error("cycle_end spacing wrong in two clock mode");
	cycle_four_a: assert property (
		cfg_word[CFG_CYCLE_CLK_BIT][*8] ##0 (cycle_end && !osc_stop) |=> !cycle_end[*3] ##1 cycle_end)
		else $error("cycle_end spacing wrong in four clock mode");
	pc_on_end_a: assert property ($changed(prog_addr) |-> cycle_end)
		else $error("prog_addr changed outside a cycle end");
	write_pulse_a: assert property (reg_we |-> cycle_end ##1 !reg_we)
		else $error("reg_we not a one clock pulse at cycle end");
	bank_bits_a: assert property (
		reg_we |-> reg_addr[7:6] == bank_select_register[BANK_HI:BANK_LO])
		else $error("register write address lacks bank bits");
	ioc_write_a: assert property (
		ioc_we |-> ioc_wdata == acc && ioc_sel >= IOC_FIRST && cycle_end ##1 !ioc_we)
		else $error("io control write malformed");
	sleep_effect_a: assert property (
		$rose(osc_stop) |-> watchdog_clear && status[ST_TIMEO] && !status[ST_PWRDN])
		else $error("sleep did not clear watchdog or set flags");
	sleep_frozen_a: assert property (
		osc_stop && $past(osc_stop) |-> !cycle_end && !reg_we && $stable(prog_addr))
		else $error("core active while oscillator stopped");
	gie_on_end_a: assert property ($changed(gie) |-> cycle_end)
		else $error("gie changed outside a cycle end");
endmodule

bind mid_core mid_core_properties u_props (
	.ref_clk(ref_clk), .nrst(nrst), .cfg_word(cfg_word), .prog_addr(prog_addr),
	.reg_addr(reg_addr), .reg_we(reg_we), .ioc_sel(ioc_sel), .ioc_wdata(ioc_wdata),
	.ioc_we(ioc_we), .acc(acc), .status(status), .bank_select_register(bank_select_register),
	.gie(gie), .osc_stop(osc_stop), .watchdog_clear(watchdog_clear), .cycle_end(cycle_end)
);

//--- verification/mid_prog_mem.sv
// program memory, register file and io control model facing the core
// assumes the bench loads rom through hierarchy before reset release
module mid_prog_mem
	import mid_pkg::*;
(
	// clock
	input wire logic               ref_clk,
	// program memory
	input wire logic [PC_W-1:0]    prog_addr,
	output logic     [WORD_W-1:0]  prog_data,
	// register file
	input wire logic [7:0]         reg_addr,
	input wire logic [7:0]         reg_wdata,
	input wire logic               reg_we,
	output logic     [7:0]         reg_rdata,
	// io control
	input wire logic [3:0]         ioc_sel,
	output logic     [7:0]         ioc_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [WORD_W-1:0] rom [1024];
	logic [7:0]        ram [256];

	initial begin
		foreach (rom[i]) rom[i] = 13'h0000;
		foreach (ram[i]) ram[i] = 8'h00;
	end
	assign prog_data = rom[prog_addr];
	assign reg_rdata = ram[reg_addr];
	assign ioc_rdata = {4'hC, ioc_sel};
	always @(posedge ref_clk) begin
		if (reg_we) ram[reg_addr] <= reg_wdata;
	end
endmodule

//--- verification/mid_core_test.sv
// self-checking bench for the decode and timing core
// assumes the memory model answers reads combinationally
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module mid_core_test
	import mid_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [12:0] w; logic skp; logic [7:0] a; logic [2:0] fl;} mid_row_t;
	logic ref_clk, nrst, reg_we, ioc_we, gie, osc_stop, watchdog_clear, cycle_end;
	logic [WORD_W-1:0] cfg_word, prog_data;
	logic [PC_W-1:0]   prog_addr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ioc_wdata, ioc_rdata, acc, status, bank, cont;
	logic [3:0]        ioc_sel;
	int n_mismatch = 0, comparisons = 0, cyc_cnt = 0, c;
	// word, skip taken, acc, {zero, digit carry, carry} after the instruction
	mid_row_t rows [29] = '{
		'{13'h0000, 1'b0, 8'h00, 3'h0}, '{13'h185A, 1'b0, 8'h5A, 3'h0},
		'{13'h0050, 1'b0, 8'h5A, 3'h0}, '{13'h0080, 1'b0, 8'h00, 3'h4},
		'{13'h1FFF, 1'b0, 8'hFF, 3'h0}, '{13'h1F01, 1'b0, 8'h00, 3'h7},
		'{13'h0410, 1'b0, 8'h5A, 3'h3}, '{13'h0A10, 1'b0, 8'h5A, 3'h3},
		'{13'h0990, 1'b0, 8'h5A, 3'h3}, '{13'h0410, 1'b0, 8'h1B, 3'h3},
		'{13'h0F10, 1'b1, 8'h1B, 3'h3}, '{13'h18EE, 1'b0, 8'hEE, 3'h0},
		'{13'h0D10, 1'b0, 8'h1B, 3'h3}, '{13'h1D20, 1'b0, 8'h05, 3'h1},
		'{13'h0005, 1'b0, 8'h05, 3'h1}, '{13'h0016, 1'b0, 8'hC6, 3'h1},
		'{13'h0021, 1'b0, 8'hC6, 3'h1}, '{13'h1BC6, 1'b0, 8'h00, 3'h5},
		'{13'h1880, 1'b0, 8'h80, 3'h5}, '{13'h0044, 1'b0, 8'h80, 3'h5},
		'{13'h0050, 1'b0, 8'h80, 3'h5}, '{13'h0002, 1'b0, 8'h80, 3'h5},
		'{13'h1801, 1'b0, 8'h01, 3'h5}, '{13'h0051, 1'b0, 8'h01, 3'h5},
		'{13'h0591, 1'b1, 8'h00, 3'h5}, '{13'h1855, 1'b0, 8'h55, 3'h5},
		'{13'h0014, 1'b0, 8'h80, 3'h5}, '{13'h0001, 1'b0, 8'hE0, 3'h5},
		'{13'h0004, 1'b0, 8'hE0, 3'h5}};

	mid_core #(.STACK_DEPTH(8), .RESET_PC(10'h000)) u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .cfg_word(cfg_word), .prog_addr(prog_addr),
		.prog_data(prog_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_rdata(reg_rdata), .ioc_sel(ioc_sel), .ioc_wdata(ioc_wdata), .ioc_we(ioc_we),
		.ioc_rdata(ioc_rdata), .acc(acc), .status(status), .bank_select_register(bank),
		.cont(cont), .gie(gie), .osc_stop(osc_stop), .watchdog_clear(watchdog_clear),
		.cycle_end(cycle_end));
	mid_prog_mem u_mem (
		.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_data(prog_data), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata), .ioc_sel(ioc_sel),
		.ioc_rdata(ioc_rdata));

	always #20 ref_clk = ~ref_clk;

	task automatic close_out();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// called at a falling edge; counts clocks until prog_addr moves
	task automatic pc_step(output int clocks);
		logic [PC_W-1:0] start;
		start = prog_addr;
		clocks = 0;
		do begin
			@(negedge ref_clk);
			clocks++;
		end while (prog_addr === start && clocks < 40);
	endtask

	task automatic hop(input logic [PC_W-1:0] nxt, input int exp_clk);
		int clocks;
		pc_step(clocks);
		`CHK(clocks, exp_clk)
		`CHK(prog_addr, nxt)
	endtask

	task automatic do_reset(input logic four);
		nrst = 1'b0;
		cfg_word = 13'h0000;
		cfg_word[CFG_CYCLE_CLK_BIT] = four;
		repeat (3) @(negedge ref_clk);
		`CHK(prog_addr, 10'h000)
		`CHK(acc, 8'h00)
		`CHK(status, STATUS_RST)
		`CHK({gie, osc_stop, reg_we, ioc_we, watchdog_clear}, 5'h00)
		nrst = 1'b1;
	endtask

	task automatic run_rows(input int nclk, input int first_chk, input int last);
		int clocks;
		logic two;
		two = 1'b0;
		for (int i = 0; i <= last; i++) begin
			if (!(i > 0 && rows[i - 1].skp)) begin
				`CHK(prog_addr, 10'(i))
				pc_step(clocks);
				if (i >= first_chk) `CHK(clocks, (two ? 2 : 1) * nclk)
				`CHK(prog_addr, 10'(i + (rows[i].skp ? 2 : 1)))
				`CHK(acc, rows[i].a)
				`CHK(status[2:0], rows[i].fl)
				two = rows[i].skp;
			end
		end
	endtask

	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			n_mismatch++;
			close_out();
		end
	end

	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		cfg_word = 13'h0000;
		@(negedge ref_clk);
		foreach (rows[i]) u_mem.rom[i] = rows[i].w;
		u_mem.rom[29] = 13'h15F0;
		u_mem.rom[10'h1F0] = 13'h1810;
		u_mem.rom[10'h1F1] = ENC_TABLE;
		u_mem.rom[10'h103] = 13'h1200;
		u_mem.rom[10'h200] = ENC_RET_INT;
		u_mem.rom[10'h104] = ENC_DISI;
		u_mem.rom[10'h105] = ENC_SLEEP;
		do_reset(1'b0);
		run_rows(2, 1, 28);
		`CHK(bank, 8'h80)
		`CHK(u_mem.ram[8'h90], 8'h80)
		`CHK(u_mem.ram[8'h91], 8'h01)
		`CHK(u_mem.ram[8'h10], 8'h1B)
		`CHK(cont, 8'h80)
		`CHK(watchdog_clear, 1'b1)
		hop(10'h1F0, 2);
		hop(10'h1F1, 4);
		pc_step(c);
		`CHK(c, 2)
		`CHK(prog_addr[9:8], 2'h1)
		`CHK(status[2:0], 3'h1)
		pc_step(c);
		`CHK(c, 4)
		pc_step(c);
		`CHK(c, 2)
		`CHK(prog_addr, 10'h103)
		hop(10'h200, 2);
		hop(10'h104, 4);
		`CHK(gie, 1'b1)
		hop(10'h105, 4);
		`CHK(gie, 1'b0)
		pc_step(c);
		`CHK(c, 2)
		`CHK(watchdog_clear, 1'b1)
		@(negedge ref_clk);
		`CHK(osc_stop, 1'b1)
		`CHK(status[ST_TIMEO:ST_PWRDN], 2'h2)
		c = prog_addr;
		repeat (10) @(negedge ref_clk);
		`CHK(prog_addr, 10'(c))
		do_reset(1'b1);
		run_rows(4, 3, 5);
		close_out();
	end
endmodule
